// [rtl/cilm_defines.svh]
// Register offsets, field positions, reset values and widths for the charger event latch.
`ifndef CILM_DEFINES_SVH
`define CILM_DEFINES_SVH
`define CILM_FLAGS_OFFSET 8'h30
`define CILM_MASKS_OFFSET 8'h31
`define CILM_FLAGS_RESET 8'h00
`define CILM_MASKS_RESET 8'hce
`define CILM_BIT_RSVD 0
`define CILM_BIT_THM 1
`define CILM_BIT_BAT 2
`define CILM_BIT_CHG 3
`define CILM_BIT_UV 4
`define CILM_BIT_OV 5
`define CILM_BIT_TOPOFF 6
`define CILM_BIT_ILIM 7
`define CILM_NSRC 8
`define CILM_BATDET_W 2
`define CILM_THM_DTL_W 3
`define CILM_THM_COLD 3'h1
`define CILM_THM_HOT 3'h5
`define CILM_ZERO8 8'h00
`define CILM_SNAP_THM 0
`define CILM_SNAP_BFLT 1
`define CILM_SNAP_BDET 2
`define CILM_SNAP_B2S 4
`define CILM_SNAP_PRE 5
`define CILM_SNAP_CHG 6
`define CILM_SNAP_UV 7
`define CILM_SNAP_OV 8
`define CILM_SNAP_TOP 9
`define CILM_SNAP_REG 10
`define CILM_SNAP_INV 11
`define CILM_SNAP_BST 12
`define CILM_SNAP_W 13
`endif

// [rtl/cilm_pkg.sv]
// Types shared by the charger event latch modules.
package cilm_pkg;
   typedef logic [7:0] cilm_byte_t;
   typedef enum logic [1:0] {
      CILM_MODE_IDLE,
      CILM_MODE_CHARGER,
      CILM_MODE_BOOST
   } cilm_ilim_mode_t;
endpackage : cilm_pkg

// [rtl/cilm_flag_cell.sv]
// One sticky event flag, set by its event input and cleared on read.
`timescale 1ns/100ps
module cilm_flag_cell (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic event_in,
   input wire logic clear,
   output logic flag
);
   logic next_flag;

   // Set wins over clear so an event in the read cycle survives to the next read.
   always_comb begin
      next_flag = event_in | (flag & ~clear);
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         flag <= 1'b0;
      end else begin
         flag <= next_flag;
      end
   end
endmodule : cilm_flag_cell

// [rtl/cilm_latch.sv]
// Charger event flag latch and mask register with read-to-clear flags.
//
// Contract
// - Flag bit 1 sets when the thermistor fault indication changes; held until read.
// - Flag bit 2 sets when battery status or any battery detail changes.
// - Flag bit 3 sets when the charger suspended status changes.
// - Flag bit 4 sets when the input undervoltage status changes.
// - Flag bit 5 sets when the input overvoltage status changes.
// - Flag bit 6 sets when the charger enters the top-off state.
// - In charger mode, bit 7 sets on input-limit regulating or invalid change.
// - In reverse boost mode, bit 7 sets on boost output limit change.
// - Reading a flag clears it; flags reset to zero; bit 0 reads zero.
// - Mask bits 1 to 7 suppress their source when one; bit 0 reserved.
// - Mask register resets to a value masking all but undervoltage and overvoltage.
// - Thermistor fault is one when temperature detail shows out of charging range.
`timescale 1ns/100ps
`include "cilm_defines.svh"
module cilm_latch
   import cilm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] thermistor_detail,
   input wire logic battery_fault_status,
   input wire logic [1:0] battery_detect_detail,
   input wire logic battery_to_system_detail,
   input wire logic precharge_threshold_detail,
   input wire logic charger_suspended_status,
   input wire logic input_undervoltage_status,
   input wire logic input_overvoltage_status,
   input wire logic topoff_status,
   input wire logic input_limit_regulating_status,
   input wire logic input_limit_invalid_status,
   input wire logic boost_output_limit_status,
   input wire logic charger_enabled,
   input wire logic boost_enabled,
   output logic thermistor_fault_status,
   output logic irq
);
   // Combined snapshot of every watched status, compared cycle to cycle.
   localparam int SNAP_W = `CILM_SNAP_W;

   logic [SNAP_W-1:0] snap;
   logic [SNAP_W-1:0] prev_snap;
   logic [SNAP_W-1:0] next_prev_snap;
   logic snap_valid;
   logic next_snap_valid;
   cilm_byte_t masks;
   cilm_byte_t next_masks;
   cilm_byte_t flags;
   cilm_byte_t events;
   cilm_byte_t clears;
   cilm_byte_t next_rdata;
   logic next_irq;
   logic next_thm_fault;
   logic thm_now;
   cilm_ilim_mode_t ilim_mode;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   always_comb begin
      thm_now = (thermistor_detail == `CILM_THM_COLD) ||
         (thermistor_detail == `CILM_THM_HOT);
      next_thm_fault = thm_now;
   end

   // Boost wins if both enables are up, so bit 7 never takes the charger and boost sources at once.
   always_comb begin
      if (boost_enabled) begin
         ilim_mode = CILM_MODE_BOOST;
      end else if (charger_enabled) begin
         ilim_mode = CILM_MODE_CHARGER;
      end else begin
         ilim_mode = CILM_MODE_IDLE;
      end
   end

   always_comb begin
      snap = '0;
      snap[`CILM_SNAP_THM] = thm_now;
      snap[`CILM_SNAP_BFLT] = battery_fault_status;
      snap[`CILM_SNAP_BDET +: `CILM_BATDET_W] = battery_detect_detail;
      snap[`CILM_SNAP_B2S] = battery_to_system_detail;
      snap[`CILM_SNAP_PRE] = precharge_threshold_detail;
      snap[`CILM_SNAP_CHG] = charger_suspended_status;
      snap[`CILM_SNAP_UV] = input_undervoltage_status;
      snap[`CILM_SNAP_OV] = input_overvoltage_status;
      snap[`CILM_SNAP_TOP] = topoff_status;
      snap[`CILM_SNAP_REG] = input_limit_regulating_status;
      snap[`CILM_SNAP_INV] = input_limit_invalid_status;
      snap[`CILM_SNAP_BST] = boost_output_limit_status;
   end

   // The first cycle after reset only takes a baseline, so power-up levels raise no flags.
   always_comb begin
      next_prev_snap = snap;
      next_snap_valid = 1'b1;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         prev_snap <= '0;
         snap_valid <= 1'b0;
      end else begin
         prev_snap <= next_prev_snap;
         snap_valid <= next_snap_valid;
      end
   end

   always_comb begin
      logic [SNAP_W-1:0] d;
      d = snap ^ prev_snap;
      events = `CILM_ZERO8;
      if (snap_valid) begin
         events[`CILM_BIT_THM] = d[`CILM_SNAP_THM];
         events[`CILM_BIT_BAT] = |d[`CILM_SNAP_PRE:`CILM_SNAP_BFLT];
         events[`CILM_BIT_CHG] = d[`CILM_SNAP_CHG];
         events[`CILM_BIT_UV] = d[`CILM_SNAP_UV];
         events[`CILM_BIT_OV] = d[`CILM_SNAP_OV];
         events[`CILM_BIT_TOPOFF] = snap[`CILM_SNAP_TOP] & ~prev_snap[`CILM_SNAP_TOP];
         case (ilim_mode)
            CILM_MODE_CHARGER: begin
               events[`CILM_BIT_ILIM] = d[`CILM_SNAP_REG] | d[`CILM_SNAP_INV];
            end
            CILM_MODE_BOOST: begin
               events[`CILM_BIT_ILIM] = d[`CILM_SNAP_BST];
            end
            default: begin
               events[`CILM_BIT_ILIM] = 1'b0;
            end
         endcase
      end
   end

   // A read of the flag register clears every bit it returned.
   assign clears = (reg_rd && hit(reg_addr, `CILM_FLAGS_OFFSET)) ? flags : `CILM_ZERO8;

   // Bit 0 has no source, so it gets no cell and is tied to zero for good.
   genvar gi;
   generate
      for (gi = 0; gi < `CILM_NSRC; gi++) begin : g_flag
         if (gi == `CILM_BIT_RSVD) begin : g_rsvd
            assign flags[gi] = 1'b0;
         end else begin : g_cell
            cilm_flag_cell u_cell (
               .ref_clk(ref_clk),
               .resetn(resetn),
               .event_in(events[gi]),
               .clear(clears[gi]),
               .flag(flags[gi])
            );
         end
      end
   endgenerate

   // Only the mask offset is writable; writes aimed at the flags are dropped.
   always_comb begin
      next_masks = masks;
      if (reg_wr && hit(reg_addr, `CILM_MASKS_OFFSET)) begin
         next_masks = reg_wdata;
         next_masks[`CILM_BIT_RSVD] = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         masks <= `CILM_MASKS_RESET;
      end else begin
         masks <= next_masks;
      end
   end

   // Idle and unmapped cycles return zero, so a stale value never looks like a fresh read.
   always_comb begin
      next_rdata = `CILM_ZERO8;
      if (reg_rd) begin
         if (hit(reg_addr, `CILM_FLAGS_OFFSET)) begin
            next_rdata = flags;
         end else if (hit(reg_addr, `CILM_MASKS_OFFSET)) begin
            next_rdata = masks;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= `CILM_ZERO8;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // Masking only gates the request; the flags themselves keep latching.
   always_comb begin
      next_irq = |(flags & ~masks);
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   // Registered so that the status pin never carries decode glitches.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         thermistor_fault_status <= 1'b0;
      end else begin
         thermistor_fault_status <= next_thm_fault;
      end
   end
endmodule : cilm_latch

// [testbench/cilm_latch_sva.sv]
// Checker for the register port and outputs of the charger event latch.
`timescale 1ns/100ps
module cilm_latch_chk (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [2:0] thermistor_detail,
   input wire logic thermistor_fault_status,
   input wire logic irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data without a read");
   chk_flag_rsvd: assert property (reg_rd && reg_addr == 8'h30 |=> !reg_rdata[0])
      else $error("flag bit 0 set");
   chk_mask_rsvd: assert property (reg_rd && reg_addr == 8'h31 |=> !reg_rdata[0])
      else $error("mask bit 0 set");
   chk_rd_unmapped: assert property (reg_rd && reg_addr[7:1] != 7'h18 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_thm_fault: assert property (1 |=> thermistor_fault_status ==
      ($past(thermistor_detail) == 3'h1 || $past(thermistor_detail) == 3'h5))
      else $error("thermistor fault wrong");
   chk_mask_irq: assert property ((reg_wr && reg_addr == 8'h31 && reg_wdata == 8'hff)
      ##1 !reg_wr [*2] |-> !irq) else $error("irq while all masked");
   chk_mask_read: assert property ((reg_wr && reg_addr == 8'h31) ##2 (reg_rd &&
      reg_addr == 8'h31) |=> reg_rdata == ($past(reg_wdata, 3) & 8'hfe))
      else $error("mask readback wrong");
   chk_irq_reset: assert property ($rose(resetn) |-> !irq ##1 !irq)
      else $error("irq after reset");
endmodule : cilm_latch_chk
bind cilm_latch cilm_latch_chk i_cilm_latch_chk (.ref_clk, .resetn, .reg_addr, .reg_rd,
   .reg_wr, .reg_wdata, .reg_rdata, .thermistor_detail, .thermistor_fault_status, .irq);

// [testbench/cilm_host.sv]
// Host model that reads and writes the latch registers.
`timescale 1ns/100ps
module cilm_host (
   input wire logic ref_clk,
   output logic [7:0] reg_addr,
   output logic reg_rd,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end
   // Every read of the flags clears them, so reads are never issued speculatively.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = w;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~w;
   endtask : wr
endmodule : cilm_host

// [testbench/cilm_latch_tb.sv]
// Self-checking bench for the charger event latch.
`timescale 1ns/100ps
module cilm_latch_tb
   import cilm_pkg::*;
;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic reg_rd, reg_wr, irq, thermistor_fault_status;
   cilm_byte_t reg_addr, reg_wdata, reg_rdata, d;
   logic [2:0] thermistor_detail = 3'h0;
   logic [1:0] battery_detect_detail = 2'h0;
   // Charger mode is on from the start so that the limit sources feed bit 7.
   logic [11:0] s = 12'h400;
   int num_errors = 0;
   int n_tests = 0;
   always #5 ref_clk = ~ref_clk;
   cilm_host i_cilm_host (.ref_clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata);
   cilm_latch i_cilm_latch (.ref_clk, .resetn, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
      .reg_rdata, .thermistor_detail, .battery_detect_detail, .thermistor_fault_status, .irq,
      .battery_fault_status(s[0]), .battery_to_system_detail(s[1]),
      .precharge_threshold_detail(s[2]), .charger_suspended_status(s[3]),
      .input_undervoltage_status(s[4]), .input_overvoltage_status(s[5]), .topoff_status(s[6]),
      .input_limit_regulating_status(s[7]), .input_limit_invalid_status(s[8]),
      .boost_output_limit_status(s[9]), .charger_enabled(s[10]), .boost_enabled(s[11]));
   task automatic check(input cilm_byte_t seen, input cilm_byte_t exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic rdchk(input cilm_byte_t a, input cilm_byte_t exp);
      i_cilm_host.rd(a, d);
      check(d, exp);
   endtask : rdchk
   task automatic flip(input logic [11:0] m);
      @(negedge ref_clk);
      s = s ^ m;
      repeat (3) @(negedge ref_clk);
   endtask : flip
   task finish_test;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (5) @(negedge ref_clk);
      resetn = 1'b1;
      rdchk(8'h31, 8'hce);
      rdchk(8'h30, 8'h00);
      rdchk(8'h55, 8'h00);
      flip(12'h010);
      check({7'h00, irq}, 8'h01);
      rdchk(8'h30, 8'h10);
      rdchk(8'h30, 8'h00);
      check({7'h00, irq}, 8'h00);
      thermistor_detail = 3'h5;
      battery_detect_detail = 2'h2;
      flip(12'h148);
      check({7'h00, thermistor_fault_status}, 8'h01);
      check({7'h00, irq}, 8'h00);
      rdchk(8'h30, 8'hce);
      flip(12'hc00);
      // Swapping the source of bit 7 is no change of the boost limit by itself.
      rdchk(8'h30, 8'h00);
      flip(12'h2c0);
      rdchk(8'h30, 8'h80);
      i_cilm_host.wr(8'h31, 8'h00);
      rdchk(8'h31, 8'h00);
      i_cilm_host.wr(8'h31, 8'hff);
      rdchk(8'h31, 8'hfe);
      flip(12'h010);
      check({7'h00, irq}, 8'h00);
      i_cilm_host.wr(8'h31, 8'h00);
      @(negedge ref_clk);
      check({7'h00, irq}, 8'h01);
      rdchk(8'h30, 8'h10);
      // The flag is already set when the read and the next change meet in one cycle.
      flip(12'h020);
      fork
         i_cilm_host.rd(8'h30, d);
         flip(12'h020);
      join
      check(d, 8'h20);
      rdchk(8'h30, 8'h20);
      i_cilm_host.wr(8'h30, 8'hff);
      rdchk(8'h30, 8'h00);
      thermistor_detail = 3'h1;
      flip(12'h880);
      check({7'h00, thermistor_fault_status}, 8'h01);
      rdchk(8'h30, 8'h00);
      thermistor_detail = 3'h2;
      flip(12'h401);
      check({7'h00, thermistor_fault_status}, 8'h00);
      check({7'h00, irq}, 8'h01);
      rdchk(8'h30, 8'h06);
      flip(12'h002);
      check({7'h00, irq}, 8'h01);
      resetn = 1'b0;
      repeat (5) @(negedge ref_clk);
      check({7'h00, irq}, 8'h00);
      resetn = 1'b1;
      rdchk(8'h31, 8'hce);
      rdchk(8'h30, 8'h00);
      finish_test();
   end
   initial begin
      #20000;
      num_errors++;
      finish_test();
   end
endmodule : cilm_latch_tb
